//--- src/coulomb_counter_registers.v
// Register bank of the battery charge monitor: counters, clear control, sleep and wake.
`include "gauge_regs_consts.vh"
`default_nettype none

module coulomb_counter_registers #(
  parameter TICK_CYCLES        = `TICK_CYCLES,
  parameter WAKE_WINDOW_CYCLES = `WAKE_WINDOW_CYCLES
) (
  // Clock and synchronous active-low reset.
  input  wire        clk,
  input  wire        resetn,
  // Register port from the serial engine; strobes are one-cycle pulses.
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Folded address towards the flash and RAM array, which answers itself.
  output wire        mem_select,
  output wire [7:0]  mem_addr,
  // Sense front end: direction levels, converter steps and magnitude.
  input  wire        sense_charging,
  input  wire        sense_discharging,
  input  wire        vfc_step,
  input  wire [2:0]  sense_level,
  input  wire [15:0] die_temperature,
  // Supply monitor and the serial line, both taken as synchronous.
  input  wire        supply_low,
  input  wire        single_wire_line,
  // Open drain status pin and the power state of the device.
  output wire        stat_pin_o,
  output wire        stat_pin_oe_n,
  output wire        asleep,
  output wire        active
);

  // Stored state.
  reg [15:0] charge_cnt_q;     // Charge count pair.
  reg [15:0] disch_cnt_q;      // Discharge count pair.
  reg [15:0] self_cnt_q;       // Self-discharge count pair.
  reg [15:0] ctime_q;          // Charge time counter pair.
  reg [15:0] dtime_q;          // Discharge time counter pair.
  reg        ctime_ro_q;       // Charge time rollover flag.
  reg        dtime_ro_q;       // Discharge time rollover flag.
  reg        ctime_slow_q;     // Charge time runs at the slow rate.
  reg        dtime_slow_q;     // Discharge time runs at the slow rate.
  reg [4:0]  clr_q;            // Pending clear requests, one per pair.
  reg        por_q;            // Power-on indicator.
  reg        stat_q;           // Status output bit; one releases the pin.
  reg        sleep_en_q;       // Sleep enable bit.
  reg [2:0]  wake_thr_q;       // Wake threshold field.
  reg [6:0]  lock_q;           // Flash page lock bits.
  reg [31:0] tick_div_q;       // Divider from the clock to the base tick.
  reg [11:0] tick_cnt_q;       // Base ticks within the hour.
  reg [6:0]  sd_acc_q;         // Fractional self-discharge accumulator.
  reg [12:0] idle_q;           // Base ticks since the last line edge.
  reg        asleep_q;         // Device is in sleep.
  reg [31:0] upd_q;            // Cycles left in the hourly update window.
  reg        line_q;           // Previous level of the serial line.

  // Address folding: above the top, only the low byte selects a location.
  wire        aliased  = (reg_addr > `ADDR_TOP);
  wire        low_page = (reg_addr[7:0] < `ADDR_MEM_FLOOR);
  wire [15:0] eff_addr = aliased ? {7'h00, low_page, reg_addr[7:0]} : reg_addr;

  // The flash and RAM array lives outside; tell it when it is addressed.
  assign mem_select = (eff_addr[15:8] == 8'h00);
  assign mem_addr   = eff_addr[7:0];

  // Register write strobes after folding, so an aliased write lands here too.
  wire wr_clr  = reg_wr && (eff_addr == `OFF_CLEAR_CONTROL);
  wire wr_mode = reg_wr && (eff_addr == `OFF_SLEEP_WAKE_MODE);
  wire wr_lock = reg_wr && (eff_addr == `OFF_FLASH_PAGE_LOCK);

  // Base tick, once per 0.8789 s, and the derived slower ticks.
  wire tick      = (tick_div_q == TICK_CYCLES - 1);
  wire slow_tick = tick && (tick_cnt_q[7:0] == `SLOW_TICK_MASK);
  wire hour_tick = tick && (tick_cnt_q == 12'hFFF);

  // The analog front end sleeps with the device.
  wire charging    = sense_charging && !asleep_q;
  wire discharging = sense_discharging && !asleep_q;

  // Line edge of either direction; the line is taken as synchronous.
  wire line_edge = single_wire_line ^ line_q;

  // Current below the wake threshold, or threshold zero meaning always.
  wire below_thr = (wake_thr_q == 3'h0) || (sense_level < wake_thr_q);

  // Time counter steps, fast or slow according to their rate state.
  wire ctime_inc  = charging && (ctime_slow_q ? slow_tick : tick);
  wire dtime_inc  = discharging && (dtime_slow_q ? slow_tick : tick);
  wire ctime_wrap = ctime_inc && (ctime_q == 16'hFFFF);
  wire dtime_wrap = dtime_inc && (dtime_q == 16'hFFFF);

  // Self-discharge weight per sixteenth hour, 128 units making one count.
  reg [7:0] sd_weight;
  always @* begin
    if (die_temperature < `TEMP_0C) begin
      sd_weight = 8'h01;
    end else if (die_temperature < `TEMP_10C) begin
      sd_weight = 8'h02;
    end else if (die_temperature < `TEMP_20C) begin
      sd_weight = 8'h04;
    end else if (die_temperature < `TEMP_30C) begin
      sd_weight = 8'h08;
    end else if (die_temperature < `TEMP_40C) begin
      sd_weight = 8'h10;
    end else if (die_temperature < `TEMP_50C) begin
      sd_weight = 8'h20;
    end else if (die_temperature < `TEMP_60C) begin
      sd_weight = 8'h40;
    end else begin
      sd_weight = 8'h80;
    end
  end

  // Accumulator sum; its top bit is a whole self-discharge count.
  wire [7:0] sd_sum  = {1'b0, sd_acc_q} + sd_weight;
  wire       sd_step = slow_tick && sd_sum[7];

  // Timebase keeps running in sleep, since self-discharge needs it.
  // The divider is 32 bits wide so the full 0.8789 s divide fits; a shorter
  // count can be given through the parameter to keep simulations brief.
  always @(posedge clk) begin
    if (!resetn) begin
      tick_div_q <= 32'h00000000;
      tick_cnt_q <= 12'h000;
      sd_acc_q   <= 7'h00;
    end else begin
      tick_div_q <= tick ? 32'h00000000 : tick_div_q + 32'h00000001;
      if (tick) begin
        tick_cnt_q <= tick_cnt_q + 12'h001;
      end
      if (slow_tick) begin
        sd_acc_q <= sd_sum[6:0];
      end
    end
  end

  // Clear requests: a written one is held for one cycle, then done by hardware.
  // A new write in the cycle the old request retires still takes effect.
  // Holding the request only one cycle saves the host a second write, and
  // a read in that cycle is the only way to see a pending bit.
  always @(posedge clk) begin
    if (!resetn) begin
      clr_q <= 5'h00;
    end else if (wr_clr) begin
      clr_q <= reg_wdata[4:0];
    end else begin
      clr_q <= 5'h00;
    end
  end

  // Coulomb count pairs; a pending clear beats a step in the same cycle.
  // A step lost to a clear is one count of 3.05 uVh, far below what the
  // host can resolve, so no step is carried over.
  always @(posedge clk) begin
    if (!resetn) begin
      charge_cnt_q <= `RST_COUNT;
      disch_cnt_q  <= `RST_COUNT;
      self_cnt_q   <= `RST_COUNT;
    end else begin
      if (clr_q[`CLR_CHARGE_CNT_BIT]) begin
        charge_cnt_q <= 16'h0000;
      end else if (charging && vfc_step) begin
        charge_cnt_q <= charge_cnt_q + 16'h0001;
      end
      if (clr_q[`CLR_DISCH_CNT_BIT]) begin
        disch_cnt_q <= 16'h0000;
      end else if (discharging && vfc_step) begin
        disch_cnt_q <= disch_cnt_q + 16'h0001;
      end
      if (clr_q[`CLR_SELF_DISCH_BIT]) begin
        self_cnt_q <= 16'h0000;
      end else if (sd_step) begin
        self_cnt_q <= self_cnt_q + 16'h0001;
      end
    end
  end

  // Time counters with rollover flags; the flag toggles on each wrap,
  // while the slow rate stays until the host clears the pair.
  // A wrap in the cycle of a clear is dropped with the count, since a flag
  // would otherwise describe a pair that has just been zeroed.
  always @(posedge clk) begin
    if (!resetn) begin
      ctime_q      <= `RST_COUNT;
      dtime_q      <= `RST_COUNT;
      ctime_ro_q   <= 1'b0;
      dtime_ro_q   <= 1'b0;
      ctime_slow_q <= 1'b0;
      dtime_slow_q <= 1'b0;
    end else begin
      if (clr_q[`CLR_CHARGE_TIME_BIT]) begin
        ctime_q      <= 16'h0000;
        ctime_ro_q   <= 1'b0;
        ctime_slow_q <= 1'b0;
      end else if (ctime_inc) begin
        ctime_q <= ctime_q + 16'h0001;
        if (ctime_wrap) begin
          ctime_ro_q   <= !ctime_ro_q;
          ctime_slow_q <= 1'b1;
        end
      end
      if (clr_q[`CLR_DISCH_TIME_BIT]) begin
        dtime_q      <= 16'h0000;
        dtime_ro_q   <= 1'b0;
        dtime_slow_q <= 1'b0;
      end else if (dtime_inc) begin
        dtime_q <= dtime_q + 16'h0001;
        if (dtime_wrap) begin
          dtime_ro_q   <= !dtime_ro_q;
          dtime_slow_q <= 1'b1;
        end
      end
    end
  end

  // Power-on and status bits. Low supply sets the indicator and wins over
  // a host clear in the same cycle; writing one to it does nothing.
  always @(posedge clk) begin
    if (!resetn) begin
      por_q  <= 1'b1;
      stat_q <= 1'b1;
    end else begin
      if (supply_low) begin
        por_q <= 1'b1;
      end else if (wr_clr && !reg_wdata[`CLR_POWER_ON_BIT]) begin
        por_q <= 1'b0;
      end
      if (wr_clr) begin
        stat_q <= reg_wdata[`CLR_STATUS_OUT_BIT];
      end
    end
  end

  // Open drain status pin: pull low while the bit is zero, else release.
  assign stat_pin_o    = 1'b0;
  assign stat_pin_oe_n = stat_q;

  // Mode fields and page locks. Page lock bits behave like flash:
  // a write can only drop a bit, never raise it again.
  always @(posedge clk) begin
    if (!resetn) begin
      wake_thr_q <= `RST_WAKE_THR;
      lock_q     <= `RST_PAGE_LOCK;
    end else begin
      if (wr_mode) begin
        wake_thr_q <= reg_wdata[`MODE_WAKE_THR_LSB +: 3];
      end
      if (wr_lock) begin
        lock_q <= lock_q & reg_wdata[6:0];
      end
    end
  end

  // Sleep controller: idle timer, entry, wake on line edge, hourly window.
  // The idle timer saturates at an hour instead of wrapping, so a long quiet
  // spell can never look like fresh activity. The sleep enable bit ignores mode
  // writes while asleep, though the wake threshold field still takes them:
  // the host must wake the device with a line edge before it talks.
  always @(posedge clk) begin
    if (!resetn) begin
      line_q     <= 1'b1;
      idle_q     <= 13'h0000;
      asleep_q   <= 1'b0;
      sleep_en_q <= 1'b1;
      upd_q      <= 32'h00000000;
    end else begin
      line_q <= single_wire_line;
      if (line_edge) begin
        idle_q <= 13'h0000;
      end else if (tick && (idle_q != `TICKS_PER_HOUR)) begin
        idle_q <= idle_q + 13'h0001;
      end
      if (asleep_q) begin
        if (line_edge) begin
          asleep_q   <= 1'b0;
          sleep_en_q <= 1'b1;
          upd_q      <= 32'h00000000;
        end else if (hour_tick) begin
          upd_q <= WAKE_WINDOW_CYCLES;
        end else if (upd_q != 32'h00000000) begin
          upd_q <= upd_q - 32'h00000001;
        end
      end else begin
        if (wr_mode) begin
          sleep_en_q <= reg_wdata[`MODE_SLEEP_EN_BIT];
        end
        if (!line_edge && (idle_q == `TICKS_PER_HOUR) && sleep_en_q && below_thr) begin
          asleep_q <= 1'b1;
        end
      end
    end
  end

  // Active tells the analog side when to be powered: always when awake, and
  // for the short update window while asleep.
  assign asleep = asleep_q;
  assign active = !asleep_q || (upd_q != 32'h00000000);

  // Read data, registered one cycle after the strobe. Reserved bits and
  // array addresses read zero here; the array answers on its own path.
  // Reading has no side effects, so the host may read the two bytes of a
  // pair in either order; a carry between the reads is not guarded.
  always @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (eff_addr == `OFF_FLASH_PAGE_LOCK) begin
        reg_rdata <= {1'b0, lock_q};
      end else if (eff_addr == `OFF_TEMPERATURE_LOW) begin
        reg_rdata <= die_temperature[7:0];
      end else if (eff_addr == `OFF_TEMPERATURE_HIGH) begin
        reg_rdata <= die_temperature[15:8];
      end else if (eff_addr == `OFF_CLEAR_CONTROL) begin
        reg_rdata <= {1'b0, por_q, stat_q, clr_q};
      end else if (eff_addr == `OFF_SLEEP_WAKE_MODE) begin
        reg_rdata <= {1'b0, sleep_en_q, ctime_ro_q, dtime_ro_q, wake_thr_q, 1'b0};
      end else if (eff_addr == `OFF_CHARGE_TIME_LOW) begin
        reg_rdata <= ctime_q[7:0];
      end else if (eff_addr == `OFF_CHARGE_TIME_HIGH) begin
        reg_rdata <= ctime_q[15:8];
      end else if (eff_addr == `OFF_DISCH_TIME_LOW) begin
        reg_rdata <= dtime_q[7:0];
      end else if (eff_addr == `OFF_DISCH_TIME_HIGH) begin
        reg_rdata <= dtime_q[15:8];
      end else if (eff_addr == `OFF_SELF_DISCH_LOW) begin
        reg_rdata <= self_cnt_q[7:0];
      end else if (eff_addr == `OFF_SELF_DISCH_HIGH) begin
        reg_rdata <= self_cnt_q[15:8];
      end else if (eff_addr == `OFF_CHARGE_CNT_LOW) begin
        reg_rdata <= charge_cnt_q[7:0];
      end else if (eff_addr == `OFF_CHARGE_CNT_HIGH) begin
        reg_rdata <= charge_cnt_q[15:8];
      end else if (eff_addr == `OFF_DISCH_CNT_LOW) begin
        reg_rdata <= disch_cnt_q[7:0];
      end else if (eff_addr == `OFF_DISCH_CNT_HIGH) begin
        reg_rdata <= disch_cnt_q[15:8];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

//--- src/gauge_regs_consts.vh
// Constants for the coulomb counter register bank: offsets, fields, resets and timing.
`ifndef GAUGE_REGS_CONSTS_VH
`define GAUGE_REGS_CONSTS_VH

// Highest decoded address and the aliasing geometry above it.
`define ADDR_TOP             16'h011F
`define ADDR_ALIAS_START     16'h0120
`define ADDR_MEM_FLOOR       8'h20

// Register offsets.
`define OFF_RESERVED         16'h0100
`define OFF_FLASH_PAGE_LOCK  16'h0101
`define OFF_TEMPERATURE_LOW  16'h0102
`define OFF_TEMPERATURE_HIGH 16'h0103
`define OFF_CLEAR_CONTROL    16'h0104
`define OFF_SLEEP_WAKE_MODE  16'h0105
`define OFF_CHARGE_TIME_LOW  16'h0106
`define OFF_CHARGE_TIME_HIGH 16'h0107
`define OFF_DISCH_TIME_LOW   16'h0108
`define OFF_DISCH_TIME_HIGH  16'h0109
`define OFF_SELF_DISCH_LOW   16'h010A
`define OFF_SELF_DISCH_HIGH  16'h010B
`define OFF_CHARGE_CNT_LOW   16'h010C
`define OFF_CHARGE_CNT_HIGH  16'h010D
`define OFF_DISCH_CNT_LOW    16'h010E
`define OFF_DISCH_CNT_HIGH   16'h010F

// Clear control field positions.
`define CLR_DISCH_CNT_BIT    0
`define CLR_CHARGE_CNT_BIT   1
`define CLR_SELF_DISCH_BIT   2
`define CLR_DISCH_TIME_BIT   3
`define CLR_CHARGE_TIME_BIT  4
`define CLR_STATUS_OUT_BIT   5
`define CLR_POWER_ON_BIT     6

// Sleep and wake mode field positions.
`define MODE_WAKE_THR_LSB    1
`define MODE_DISCH_RO_BIT    4
`define MODE_CHARGE_RO_BIT   5
`define MODE_SLEEP_EN_BIT    6

// Reset values.
`define RST_WAKE_THR         3'h7
`define RST_PAGE_LOCK        7'h7F
`define RST_COUNT            16'h0000

// Timing: base tick of 0.8789 s, 4096 ticks to the hour, 4 s update window.
`define CLK_PERIOD_NS        50
`define TICK_PERIOD_NS       878900000
`define TICK_CYCLES          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// Four seconds in nanoseconds, sized unsigned since it passes the signed 32-bit range.
`define WAKE_WINDOW_NS       32'hEE6B2800
`define WAKE_WINDOW_CYCLES   (`WAKE_WINDOW_NS / `CLK_PERIOD_NS)
`define TICKS_PER_HOUR       13'h1000
`define SLOW_TICK_MASK       8'hFF

// Die temperature steps in quarter kelvin: 0, 10, 20, 30, 40, 50 and 60 degrees C.
`define TEMP_0C              16'h0444
`define TEMP_10C             16'h046C
`define TEMP_20C             16'h0494
`define TEMP_30C             16'h04BC
`define TEMP_40C             16'h04E4
`define TEMP_50C             16'h050C
`define TEMP_60C             16'h0534

`endif

//--- bench/coulomb_counter_registers_chk.sv
// Port-level checker for the coulomb counter register bank.
`default_nettype none
module coulomb_counter_registers_chk #(
  parameter int TICK_CYCLES        = 4,
  parameter int WAKE_WINDOW_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        mem_select,
  input wire logic [7:0]  mem_addr,
  input wire logic        supply_low,
  input wire logic        single_wire_line,
  input wire logic        stat_pin_o,
  input wire logic        stat_pin_oe_n,
  input wire logic        asleep,
  input wire logic        active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        line_q;  // Line level one cycle ago.
  logic [31:0] quiet_q; // Cycles since the line last moved.
  logic [31:0] win_q;   // Length of the current hourly window.
  // Line level is copied during reset too, so no false edge follows release.
  always_ff @(posedge clk) begin
    line_q <= single_wire_line;
    if (!resetn || single_wire_line != line_q) quiet_q <= 32'h0;
    else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
    win_q <= (resetn && asleep && active) ? win_q + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_fold_high: assert property (
    reg_addr > 16'h011F |-> mem_addr == reg_addr[7:0] && mem_select == (reg_addr[7:0] >= 8'h20))
    else $error("aliased address folded wrongly");
  a_array_low: assert property (
    reg_addr <= 16'h00FF |-> mem_select && mem_addr == reg_addr[7:0])
    else $error("array address not passed through");
  a_reg_space: assert property (
    reg_addr >= 16'h0100 && reg_addr <= 16'h011F |-> !mem_select)
    else $error("register address sent to the array");
  a_void_read: assert property (
    reg_rd && (mem_select || reg_addr == 16'h0100) |=> reg_rdata == 8'h00)
    else $error("reserved or array read not zero");
  a_stat_drain: assert property (stat_pin_o == 1'b0)
    else $error("status pin drives high");
  a_stat_write: assert property (
    reg_wr && reg_addr == 16'h0104 |=> stat_pin_oe_n == $past(reg_wdata[5]))
    else $error("status pin does not follow its bit");
  a_por_sticky: assert property (
    supply_low [*2] ##1 (reg_rd && !reg_wr && reg_addr == 16'h0104) |=> reg_rdata[6])
    else $error("power-on bit not set by low supply");
  a_wake_edge: assert property (
    asleep && single_wire_line != line_q |-> ##[1:3] !asleep)
    else $error("line edge did not wake the device");
  a_awake_active: assert property (!asleep |-> active)
    else $error("awake device not active");
  a_sleep_quiet: assert property (
    $rose(asleep) |-> quiet_q >= 4095 * TICK_CYCLES)
    else $error("sleep entered before an idle hour");
  a_window_len: assert property (win_q <= WAKE_WINDOW_CYCLES)
    else $error("hourly update window too long");
endmodule
bind coulomb_counter_registers coulomb_counter_registers_chk #(
  .TICK_CYCLES(TICK_CYCLES), .WAKE_WINDOW_CYCLES(WAKE_WINDOW_CYCLES)) chk (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_select(mem_select), .mem_addr(mem_addr),
  .supply_low(supply_low), .single_wire_line(single_wire_line), .stat_pin_o(stat_pin_o),
  .stat_pin_oe_n(stat_pin_oe_n), .asleep(asleep), .active(active));
`default_nettype wire

//--- bench/host_model.sv
// Host controller model: register transfers and the single-wire line level.
`default_nettype none
module host_model (
  input  wire logic        clk,
  output var  logic [15:0] reg_addr,
  output var  logic        reg_wr,
  output var  logic [7:0]  reg_wdata,
  output var  logic        reg_rd,
  input  wire logic [7:0]  reg_rdata,
  output var  logic        single_wire_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus; the line rests high on its pull-up.
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    single_wire_line = 1'b1;
  end
  // One write; data is scrambled once the strobe drops so stale data cannot pass.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One read; the registered answer is taken once it has settled.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // Clearing both time pairs keeps status released and the power-on bit.
  task automatic clear_times();
    wr(16'h0104, 8'h78);
  endtask
  // Any line edge counts as activity.
  task automatic bump();
    @(posedge clk);
    single_wire_line <= ~single_wire_line;
  endtask
endmodule
`default_nettype wire

//--- bench/coulomb_counter_registers_test.sv
// Self-checking testbench for the coulomb counter register bank.
`default_nettype none
module coulomb_counter_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn, sense_charging, sense_discharging, vfc_step, supply_low;
  logic [2:0] sense_level;
  logic [15:0] die_temperature, reg_addr;
  logic reg_wr, reg_rd, mem_select, single_wire_line, stat_pin_o, stat_pin_oe_n, asleep, active;
  logic [7:0] reg_wdata, reg_rdata, mem_addr;
  int miscompares, compares, cycles, n;
  always #25 clk = ~clk;
  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .single_wire_line(single_wire_line));
  coulomb_counter_registers #(.TICK_CYCLES(4), .WAKE_WINDOW_CYCLES(10)) dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_select(mem_select), .mem_addr(mem_addr),
    .sense_charging(sense_charging), .sense_discharging(sense_discharging),
    .vfc_step(vfc_step), .sense_level(sense_level), .die_temperature(die_temperature),
    .supply_low(supply_low), .single_wire_line(single_wire_line), .stat_pin_o(stat_pin_o),
    .stat_pin_oe_n(stat_pin_oe_n), .asleep(asleep), .active(active));
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Byte comparison; case inequality so unknowns never match.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register read followed by a comparison.
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(nm, e, d);
  endtask
  // Converter steps, one every other cycle.
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk) vfc_step <= 1'b1;
      @(posedge clk) vfc_step <= 1'b0;
    end
  endtask
  // Values seen straight after reset.
  task automatic t_reset();
    rdchk("clear_control", 16'h0104, 8'h60);
    rdchk("sleep_wake_mode", 16'h0105, 8'h4E);
    rdchk("flash_page_lock", 16'h0101, 8'h7F);
    rdchk("charge_count_low", 16'h010C, 8'h00);
  endtask
  // Charge and discharge counts, a refused write and the clear bits.
  task automatic t_counts();
    logic [7:0] d;
    @(posedge clk) sense_charging <= 1'b1;
    pulse(5);
    @(posedge clk) sense_charging <= 1'b0;
    sense_discharging <= 1'b1;
    pulse(3);
    @(posedge clk) sense_discharging <= 1'b0;
    rdchk("charge_count_low", 16'h010C, 8'h05);
    rdchk("discharge_count_low", 16'h010E, 8'h03);
    host.wr(16'h010C, 8'hAA);
    rdchk("charge_count_low", 16'h010C, 8'h05);
    host.rd(16'h0106, d);
    chk("charge_time_low moved", 8'h01, {7'h0, d != 8'h00});
    host.rd(16'h0108, d);
    chk("discharge_time_low moved", 8'h01, {7'h0, d != 8'h00});
    host.wr(16'h0104, 8'h61);
    rdchk("clear_control", 16'h0104, 8'h60);
    rdchk("discharge_count_low", 16'h010E, 8'h00);
    rdchk("charge_count_low", 16'h010C, 8'h05);
    host.clear_times();
    rdchk("charge_time_low", 16'h0106, 8'h00);
    rdchk("discharge_time_low", 16'h0108, 8'h00);
  endtask
  // Reserved, aliased and array addresses.
  task automatic t_alias();
    rdchk("alias of mode", 16'h0305, 8'h4E);
    rdchk("reserved", 16'h0100, 8'h00);
    rdchk("array read", 16'h0250, 8'h00);
    chk("mem_addr", 8'h50, mem_addr);
  endtask
  // Status pin and the power-on bit.
  task automatic t_status();
    host.wr(16'h0104, 8'h40);
    @(negedge clk);
    chk("stat_pin_oe_n", 8'h00, {7'h0, stat_pin_oe_n});
    host.wr(16'h0104, 8'h20);
    rdchk("clear_control", 16'h0104, 8'h20);
    host.wr(16'h0104, 8'h60);
    rdchk("clear_control", 16'h0104, 8'h20);
    @(posedge clk) supply_low <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("clear_control", 16'h0104, 8'h60);
    @(posedge clk) supply_low <= 1'b0;
  endtask
  // Sleep entry, hourly window, self-discharge and wake by a line edge.
  task automatic t_sleep();
    logic [7:0] d;
    @(posedge clk) sense_level <= 3'h7;
    host.wr(16'h0105, 8'h40);
    rdchk("sleep_wake_mode", 16'h0105, 8'h40);
    n = 0;
    while (asleep !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("asleep", 8'h01, {7'h0, asleep});
    n = 0;
    while (!(asleep === 1'b1 && active === 1'b1) && n < 20000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (active === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("window length", 8'h0A, n[7:0]);
    host.bump();
    repeat (3) @(negedge clk);
    chk("asleep", 8'h00, {7'h0, asleep});
    rdchk("sleep_wake_mode", 16'h0105, 8'h40);
    host.rd(16'h010A, d);
    chk("self_discharge_low moved", 8'h01, {7'h0, d != 8'h00});
  endtask
  // A hang counts as a mismatch and goes to the report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    resetn = 1'b0;
    sense_charging = 1'b0;
    sense_discharging = 1'b0;
    vfc_step = 1'b0;
    supply_low = 1'b0;
    sense_level = 3'h0;
    die_temperature = 16'h04A8;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_counts();
    t_alias();
    t_status();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
